// ---- bench/pkrc_partner.sv ----
/*
 * pkrc_partner: the power push-button and the board pull-ups on the
 * host reset and interrupt lines.
 * Assumes the bench calls key_set from one process clocked on mclk_i.
 */
`timescale 1ns/1ps
module pkrc_partner (
  input wire logic mclk_i,
  input wire logic host_reset_n_i,
  input wire logic host_reset_n_oe_i,
  input wire logic irq_out_i,
  input wire logic irq_out_oe_i,
  output logic power_key_n_o,
  output logic host_reset_wire_o,
  output logic irq_wire_o
);
  // a released open-drain line floats up to the board pull-up
  assign host_reset_wire_o = host_reset_n_oe_i ? 1'b1 : host_reset_n_i;
  assign irq_wire_o = irq_out_oe_i ? 1'b1 : irq_out_i;
  // button rests released, pulled high
  initial begin
    power_key_n_o = 1'b1;
  end
  // moves just after an edge so the sync flops never see a same-step race
  task automatic key_set(input logic lv);
    @(posedge mclk_i);
    power_key_n_o <= lv;
  endtask : key_set
endmodule : pkrc_partner

// ---- bench/test_power_key_reset_irq_control.sv ----
/*
 * test_power_key_reset_irq_control: self-checking bench for pkrc_top.
 * Assumes shortened timing parameters and the package register map.
 */
`timescale 1ns/1ps
module test_power_key_reset_irq_control;
  logic mclk_i, rst_i, reset_request_n_i, external_wake_trigger_i, first_stage_done_i;
  logic second_stage_done_i, reset_to_pd_i, in_powerdown_i, seq_busy_i, power_key_n;
  logic wakeup_o, reset_req_o, fast_shutdown_o, system_on_o, standby_o, hr_wire, irq_wire;
  logic host_reset_n_o, host_reset_n_oe_o, irq_out_o, irq_out_oe_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0;
  int checked = 0;
  int n_wake = 0;
  int n_rreq = 0;
  localparam logic [7:0] CT = pkrc_pkg::CTRL_OFS;
  localparam logic [7:0] EV = pkrc_pkg::EVT_OFS;
  localparam logic [7:0] ST = pkrc_pkg::STAT_OFS;

  pkrc_top #(.MS_CYCLES(20), .TICK_CYCLES(2)) u_pkrc_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .power_key_n_i(power_key_n),
    .reset_request_n_i(reset_request_n_i), .external_wake_trigger_i(external_wake_trigger_i),
    .first_stage_done_i(first_stage_done_i), .second_stage_done_i(second_stage_done_i),
    .reset_to_pd_i(reset_to_pd_i), .in_powerdown_i(in_powerdown_i), .seq_busy_i(seq_busy_i),
    .wakeup_o(wakeup_o), .reset_req_o(reset_req_o), .fast_shutdown_o(fast_shutdown_o),
    .system_on_o(system_on_o), .standby_o(standby_o), .host_reset_n_o(host_reset_n_o),
    .host_reset_n_oe_o(host_reset_n_oe_o), .irq_out_o(irq_out_o), .irq_out_oe_o(irq_out_oe_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  pkrc_partner u_pkrc_partner (
    .mclk_i(mclk_i), .host_reset_n_i(host_reset_n_o), .host_reset_n_oe_i(host_reset_n_oe_o),
    .irq_out_i(irq_out_o), .irq_out_oe_i(irq_out_oe_o), .power_key_n_o(power_key_n),
    .host_reset_wire_o(hr_wire), .irq_wire_o(irq_wire)
  );

  // 200 mhz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // wakeup and reset request are one-cycle pulses, so count them
  always @(posedge mclk_i) begin
    if (wakeup_o === 1'b1) n_wake <= n_wake + 1;
    if (reset_req_o === 1'b1) n_rreq <= n_rreq + 1;
  end

  task automatic chk_bit(input string nm, input logic ex, input logic got);
    checked++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_word

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk_i);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge mclk_i);
    s_axi_bready <= 1'b0;
    chk_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] dt);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk_i);
    dt = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] ex);
    logic [31:0] dt;
    rd(a, 2'b00, dt);
    chk_word(nm, ex, dt & m);
  endtask : rd_chk

  task automatic press(input int hold);
    u_pkrc_partner.key_set(1'b0);
    cyc(hold);
    u_pkrc_partner.key_set(1'b1);
    cyc(30);
  endtask : press

  task automatic t_reset();
    logic [31:0] dt;
    chk_bit("host_reset_n cold", 1'b0, host_reset_n_o);
    chk_bit("system_on", 1'b1, system_on_o);
    chk_bit("irq idle", 1'b1, irq_out_o);
    rd_chk("ctrl reset", CT, 32'hffff_ffff, pkrc_pkg::CTRL_RST);
    rd_chk("time reset", pkrc_pkg::TIME_OFS, 32'hffff_ffff, pkrc_pkg::TIME_RST);
    rd(8'h40, 2'b10, dt);
    chk_word("unmapped data", 32'h0, dt);
    $display("test reset done");
  endtask : t_reset

  task automatic t_release();
    wr(pkrc_pkg::TIME_OFS, 32'h0002_0101, 2'b00);
    wr(CT, 32'h0000_0440, 2'b00);
    cyc(20);
    chk_bit("host_reset_n before trigger", 1'b0, host_reset_n_o);
    first_stage_done_i <= 1'b1;
    @(posedge mclk_i);
    first_stage_done_i <= 1'b0;
    cyc(30);
    chk_bit("host_reset_n timing", 1'b0, host_reset_n_o);
    cyc(30);
    chk_bit("host_reset_n expired", 1'b1, host_reset_n_o);
    rd_chk("stat released", ST, 32'h2, 32'h2);
    $display("test release done");
  endtask : t_release

  task automatic t_keys();
    wr(CT, 32'h0000_0400, 2'b00);
    u_pkrc_partner.key_set(1'b0);
    cyc(20);
    rd_chk("key level low", ST, 32'h1, 32'h0);
    rd_chk("event on press", EV, 32'h1, 32'h1);
    chk_bit("irq on event", 1'b0, irq_out_o);
    u_pkrc_partner.key_set(1'b1);
    cyc(20);
    rd_chk("key level high", ST, 32'h1, 32'h1);
    chk_bit("irq held", 1'b0, irq_out_o);
    wr(EV, 32'h1, 2'b00);
    cyc(2);
    chk_bit("irq cleared", 1'b1, irq_out_o);
    wr(CT, 32'h0000_0401, 2'b00);
    press(30);
    rd_chk("masked event", EV, 32'h1, 32'h0);
    chk_bit("masked irq", 1'b1, irq_out_o);
    wr(CT, 32'h0000_0402, 2'b00);
    u_pkrc_partner.key_set(1'b0);
    cyc(30);
    rd_chk("short held", EV, 32'h1, 32'h0);
    u_pkrc_partner.key_set(1'b1);
    cyc(30);
    rd_chk("short release", EV, 32'h1, 32'h1);
    wr(EV, 32'h1, 2'b00);
    u_pkrc_partner.key_set(1'b0);
    cyc(2600);
    rd_chk("long lock", CT, 32'h200, 32'h200);
    rd_chk("long event", EV, 32'h1, 32'h1);
    u_pkrc_partner.key_set(1'b1);
    wr(CT, 32'h0000_0404, 2'b00);
    wr(EV, 32'h1, 2'b00);
    press(2600);
    chk_bit("mode 10 system on", 1'b0, system_on_o);
    rd_chk("mode 10 lock", CT, 32'h200, 32'h200);
    wr(CT, 32'h0000_0406, 2'b00);
    press(30);
    chk_bit("mode 11 short system on", 1'b0, system_on_o);
    chk_bit("mode 11 short standby", 1'b1, standby_o);
    press(2600);
    chk_bit("mode 11 long standby", 1'b0, standby_o);
    rd_chk("mode 11 lock", CT, 32'h200, 32'h200);
    wr(EV, 32'h7, 2'b00);
    $display("test keys done");
  endtask : t_keys

  task automatic t_wake();
    int w0;
    wr(CT, 32'h0000_0400, 2'b00); // lock cleared before powerdown
    in_powerdown_i <= 1'b1;
    w0 = n_wake;
    press(30);
    chk_word("wake unlocked", 32'(w0 + 1), 32'(n_wake));
    wr(CT, 32'h0000_0600, 2'b00);
    press(30);
    chk_word("wake locked short", 32'(w0 + 1), 32'(n_wake));
    press(2600);
    chk_word("wake locked long", 32'(w0 + 2), 32'(n_wake));
    in_powerdown_i <= 1'b0;
    wr(EV, 32'h7, 2'b00);
    $display("test wake done");
  endtask : t_wake

  task automatic t_rreq();
    reset_request_n_i <= 1'b0;
    cyc(30);
    chk_word("reset request pulses", 32'h1, 32'(n_rreq));
    chk_bit("host_reset_n on request", 1'b0, host_reset_n_o);
    rd_chk("request logged", EV, 32'h2, 32'h2);
    reset_request_n_i <= 1'b1;
    cyc(20);
    wr(EV, 32'h2, 2'b00);
    cyc(2);
    chk_bit("irq after clear", 1'b1, irq_out_o);
    $display("test reset request done");
  endtask : t_rreq

  task automatic t_drv();
    wr(pkrc_pkg::TIME_OFS, 32'h0000_0101, 2'b00);
    wr(CT, 32'h0000_0518, 2'b00);
    chk_bit("fast shutdown", 1'b1, fast_shutdown_o);
    external_wake_trigger_i <= 1'b1;
    @(posedge mclk_i);
    external_wake_trigger_i <= 1'b0;
    cyc(4);
    chk_bit("zero delay release", 1'b1, host_reset_n_o);
    chk_bit("open drain released", 1'b1, host_reset_n_oe_o);
    chk_bit("reset wire pulled", 1'b1, hr_wire);
    chk_bit("irq high polarity idle", 1'b0, irq_out_o);
    press(30);
    chk_bit("irq high polarity active", 1'b1, irq_wire);
    chk_bit("irq open drain released", 1'b1, irq_out_oe_o);
    wr(EV, 32'h7, 2'b00);
    $display("test drivers done");
  endtask : t_drv

  // byte strobes, sleep entry and the two remaining release triggers
  task automatic t_trig();
    s_axi_wstrb <= 4'h4;
    wr(pkrc_pkg::TIME_OFS, 32'h0003_0202, 2'b00);
    s_axi_wstrb <= 4'hf;
    rd_chk("time byte lane", pkrc_pkg::TIME_OFS, 32'hffff_ffff, 32'h0003_0101);
    wr(CT, 32'h0000_00a0, 2'b00);
    seq_busy_i <= 1'b1;
    cyc(10);
    chk_bit("host_reset_n on sleep", 1'b0, host_reset_n_o);
    chk_bit("push-pull drives", 1'b0, host_reset_n_oe_o);
    seq_busy_i <= 1'b0;
    second_stage_done_i <= 1'b1;
    @(posedge mclk_i);
    second_stage_done_i <= 1'b0;
    cyc(30);
    chk_bit("stage2 timing", 1'b0, host_reset_n_o);
    cyc(40);
    chk_bit("stage2 expired", 1'b1, host_reset_n_o);
    wr(CT, 32'h0000_00e0, 2'b00);
    seq_busy_i <= 1'b1;
    cyc(10);
    seq_busy_i <= 1'b0;
    second_stage_done_i <= 1'b1;
    @(posedge mclk_i);
    second_stage_done_i <= 1'b0;
    cyc(70);
    chk_bit("stage2 ignored", 1'b0, host_reset_n_o);
    reset_to_pd_i <= 1'b1;
    @(posedge mclk_i);
    reset_to_pd_i <= 1'b0;
    cyc(70);
    chk_bit("reset to powerdown release", 1'b1, host_reset_n_o);
    $display("test triggers done");
  endtask : t_trig

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    rst_i = 1'b1;
    reset_request_n_i = 1'b1;
    {external_wake_trigger_i, first_stage_done_i, second_stage_done_i} = 3'h0;
    {reset_to_pd_i, in_powerdown_i, seq_busy_i} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    cyc(12);
    rst_i <= 1'b0;
    t_reset();
    t_release();
    t_keys();
    t_wake();
    t_rreq();
    t_drv();
    t_trig();
    summarize();
  end

  // watchdog, about five times the expected run
  initial begin
    cyc(60000);
    n_errors++;
    summarize();
  end
endmodule : test_power_key_reset_irq_control

// ---- src/pkrc_pkg.sv ----
/*
 * pkrc_pkg: constants for the power key, reset request, host reset and
 * interrupt control block. Assumes a 200 MHz clock and an AXI4-Lite
 * register bus with 32-bit data.
 */
package pkrc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] EVT_OFS = 8'h0c;
  localparam logic [7:0] SEQ_OFS = 8'h10;
  // control register fields
  localparam int CTRL_MASK_B = 0;
  localparam int CTRL_FUNC_LSB = 1;
  localparam int CTRL_FAST_B = 3;
  localparam int CTRL_ODRV_B = 4;
  localparam int CTRL_SLEEP_B = 5;
  localparam int CTRL_TRIG_LSB = 6;
  localparam int CTRL_IRQPOL_B = 8;
  localparam int CTRL_LOCK_B = 9;
  localparam int CTRL_SYSON_B = 10;
  localparam int CTRL_STBY_B = 11;
  localparam logic [31:0] CTRL_RST = 32'h0000_0400;
  // timing register: [7:0] debounce in 10 us units, [15:8] long press in 10 ms,
  // [25:16] reset release delay in ms
  localparam int TIME_DEB_LSB = 0;
  localparam int TIME_LONG_LSB = 8;
  localparam int TIME_REL_LSB = 16;
  localparam logic [31:0] TIME_RST = 32'h0014_6402;
  // event register bits, write one to clear
  localparam int EVT_KEY_B = 0;
  localparam int EVT_RREQ_B = 1;
  localparam int EVT_WAKE_B = 2;
  // clock and tick timing constants
  localparam int CLK_MHZ = 200;
  localparam int US_PER_MS = 1000;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int MS_CYC = US_PER_MS * CLK_MHZ;
  localparam int LONG_TICKS_PER_UNIT = 1000;
  // reset timer trigger codes
  typedef enum logic [1:0] {
    PKRC_TRIG_WAKE = 2'b00,
    PKRC_TRIG_STAGE1 = 2'b01,
    PKRC_TRIG_STAGE2 = 2'b10,
    PKRC_TRIG_TOPD = 2'b11
  } pkrc_trig_e;
  // key functions
  typedef enum logic [1:0] {
    PKRC_KF_EDGE = 2'b00,
    PKRC_KF_LOCK = 2'b01,
    PKRC_KF_OFF = 2'b10,
    PKRC_KF_STBY = 2'b11
  } pkrc_kf_e;
endpackage : pkrc_pkg

// ---- src/pkrc_top.sv ----
/*
 * pkrc_top: power key detection, reset request, host reset timer and
 * level interrupt, with an AXI4-Lite register slave.
 * Assumes pins are asynchronous; sequencer strobes are on mclk_i.
 */
`timescale 1ns/1ps
module pkrc_top #(
  parameter int MS_CYCLES = pkrc_pkg::MS_CYC,
  parameter int TICK_CYCLES = pkrc_pkg::TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic power_key_n_i,
  input wire logic reset_request_n_i,
  input wire logic external_wake_trigger_i,
  input wire logic first_stage_done_i,
  input wire logic second_stage_done_i,
  input wire logic reset_to_pd_i,
  input wire logic in_powerdown_i,
  input wire logic seq_busy_i,
  output logic wakeup_o,
  output logic reset_req_o,
  output logic fast_shutdown_o,
  output logic system_on_o,
  output logic standby_o,
  output logic host_reset_n_o,
  output logic host_reset_n_oe_o,
  output logic irq_out_o,
  output logic irq_out_oe_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NIN = 2;
  // merges write data into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  logic [31:0] ctrl_q, time_q;
  logic [2:0] evt_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  // shared 10 us tick for the debounce filters
  logic [15:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // three-flop sync and a debounce counter per pin; one time setting
  wire [NIN-1:0] pin_raw = {reset_request_n_i, power_key_n_i};
  wire [7:0] deb_time = time_q[pkrc_pkg::TIME_DEB_LSB +: 8];
  logic [NIN-1:0] deb_lvl;
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_deb
      logic [2:0] sy_q;
      logic [7:0] cnt_q;
      logic lvl_q;
      wire agree = (sy_q[1] == sy_q[2]);
      wire differ = agree && (sy_q[2] != lvl_q);
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) sy_q <= 3'h7;
        else sy_q <= {sy_q[1:0], pin_raw[g]};
      end
      // level accepted once stable for deb_time ticks
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_q <= 8'h00;
          lvl_q <= 1'b1;
        end else if (!differ) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= deb_time) begin
          lvl_q <= sy_q[2];
          cnt_q <= 8'h00;
        end else if (tick) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
      assign deb_lvl[g] = lvl_q;
    end
  endgenerate
  // key edges; detection never gated by power mode
  logic key_d_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) key_d_q <= 1'b1;
    else key_d_q <= deb_lvl[0];
  end
  wire key_fall = key_d_q && !deb_lvl[0];
  wire key_rise = !key_d_q && deb_lvl[0];
  // press duration in ms, restarted each press
  logic [17:0] ms_cnt_q;
  logic [17:0] press_ms_q;
  logic long_done_q;
  wire ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));
  wire [17:0] long_ms = 18'(time_q[pkrc_pkg::TIME_LONG_LSB +: 8]) * 18'd10;
  wire long_hit = !deb_lvl[0] && !long_done_q && (press_ms_q >= long_ms);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_q <= 18'h00000;
      press_ms_q <= 18'h00000;
      long_done_q <= 1'b0;
    end else if (key_fall) begin
      ms_cnt_q <= 18'h00000;
      press_ms_q <= 18'h00000;
      long_done_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
      if (ms_tick && !deb_lvl[0] && press_ms_q != 18'h3ffff) press_ms_q <= press_ms_q + 18'h00001;
      if (long_hit) long_done_q <= 1'b1;
    end
  end

  // key function decode
  wire [1:0] kf = ctrl_q[pkrc_pkg::CTRL_FUNC_LSB +: 2];
  wire kf_edge = (kf == pkrc_pkg::PKRC_KF_EDGE);
  wire short_rel = key_rise && !long_done_q;
  wire key_evt = kf_edge ? key_fall : (short_rel || long_hit);
  wire set_lock = !kf_edge && long_hit;
  wire clr_syson = (kf == pkrc_pkg::PKRC_KF_OFF && long_hit) ||
                   (kf == pkrc_pkg::PKRC_KF_STBY && (short_rel || long_hit));
  wire set_stby = (kf == pkrc_pkg::PKRC_KF_STBY) && short_rel;
  wire clr_stby = (kf == pkrc_pkg::PKRC_KF_STBY) && long_hit;
  wire key_masked = ctrl_q[pkrc_pkg::CTRL_MASK_B];
  wire lock = ctrl_q[pkrc_pkg::CTRL_LOCK_B];
  // lock demands a long press to wake
  wire wake_ok = lock ? long_hit : key_evt;
  wire key_wake = wake_ok && !key_masked && in_powerdown_i;

  // reset request: debounced falling edge
  logic rr_d_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rr_d_q <= 1'b1;
    else rr_d_q <= deb_lvl[1];
  end
  wire rr_fall = rr_d_q && !deb_lvl[1];
  // host reset: asserted on cold boot (reset), reset request, optional sleep
  wire pd_entry = seq_busy_i && !in_powerdown_i && !system_on_o;
  logic sleep_seen_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) sleep_seen_q <= 1'b0;
    else sleep_seen_q <= pd_entry;
  end
  wire sleep_start = pd_entry && !sleep_seen_q && ctrl_q[pkrc_pkg::CTRL_SLEEP_B];
  wire [1:0] trig_sel = ctrl_q[pkrc_pkg::CTRL_TRIG_LSB +: 2];
  wire trig = (trig_sel == pkrc_pkg::PKRC_TRIG_WAKE) ? external_wake_trigger_i :
              (trig_sel == pkrc_pkg::PKRC_TRIG_STAGE1) ? first_stage_done_i :
              (trig_sel == pkrc_pkg::PKRC_TRIG_STAGE2) ? second_stage_done_i :
              reset_to_pd_i;
  wire [9:0] rel_ms = time_q[pkrc_pkg::TIME_REL_LSB +: 10];
  logic hr_asserted_q, hr_timing_q;
  logic [9:0] hr_ms_q;
  logic [17:0] hr_cyc_q;
  wire hr_ms_tick = (hr_cyc_q == 18'(MS_CYCLES - 1));
  // released only after the selected trigger and the delay
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hr_asserted_q <= 1'b1;
      hr_timing_q <= 1'b0;
      hr_ms_q <= 10'h000;
      hr_cyc_q <= 18'h00000;
    end else if (rr_fall || sleep_start) begin
      hr_asserted_q <= 1'b1;
      hr_timing_q <= 1'b0;
    end else if (hr_asserted_q && !hr_timing_q && trig) begin
      if (rel_ms == 10'h000) hr_asserted_q <= 1'b0;
      else hr_timing_q <= 1'b1;
      hr_ms_q <= 10'h000;
      hr_cyc_q <= 18'h00000;
    end else if (hr_timing_q) begin
      hr_cyc_q <= hr_ms_tick ? 18'h00000 : hr_cyc_q + 18'h00001;
      if (hr_ms_tick) begin
        hr_ms_q <= hr_ms_q + 10'h001;
        if (hr_ms_q + 10'h001 >= rel_ms) begin
          hr_asserted_q <= 1'b0;
          hr_timing_q <= 1'b0;
        end
      end
    end
  end
  // open-drain drives only low; enable is active low
  wire odrv = ctrl_q[pkrc_pkg::CTRL_ODRV_B];
  assign host_reset_n_o = !hr_asserted_q;
  assign host_reset_n_oe_o = odrv ? !hr_asserted_q : 1'b0;
  assign reset_req_o = rr_fall;
  assign fast_shutdown_o = ctrl_q[pkrc_pkg::CTRL_FAST_B];
  assign wakeup_o = key_wake;
  assign system_on_o = ctrl_q[pkrc_pkg::CTRL_SYSON_B];
  assign standby_o = ctrl_q[pkrc_pkg::CTRL_STBY_B];

  // interrupt: any pending event; the key mask only keeps key and wake events from being set
  wire irq_act = evt_q[pkrc_pkg::EVT_KEY_B] | evt_q[pkrc_pkg::EVT_RREQ_B] |
                 evt_q[pkrc_pkg::EVT_WAKE_B];
  wire irq_pol = ctrl_q[pkrc_pkg::CTRL_IRQPOL_B];
  assign irq_out_o = irq_pol ? irq_act : !irq_act;
  assign irq_out_oe_o = odrv ? !(irq_out_o == 1'b0) : 1'b0;

  // AXI4-Lite decode
  wire do_wr = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_ctrl = do_wr && awaddr_q == pkrc_pkg::CTRL_OFS;
  wire wr_time = do_wr && awaddr_q == pkrc_pkg::TIME_OFS;
  wire wr_evt = do_wr && awaddr_q == pkrc_pkg::EVT_OFS;
  wire wr_ok = wr_ctrl || wr_time || wr_evt || awaddr_q == pkrc_pkg::STAT_OFS ||
               awaddr_q == pkrc_pkg::SEQ_OFS;
  wire [31:0] ctrl_m = merge(ctrl_q, wdata_q, wstrb_q);
  wire [2:0] evt_set = {key_wake, rr_fall, key_evt && !key_masked};
  wire [2:0] evt_clr = wr_evt ? (wdata_q[2:0] & {3{wstrb_q[0]}}) : 3'h0;

  // set wins over write-one-clear, so nothing is lost mid read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) evt_q <= 3'h0;
    else evt_q <= (evt_q & ~evt_clr) | evt_set;
  end

  // control: software writes first, hardware key actions take priority
  logic [31:0] ctrl_d;
  always_comb begin
    ctrl_d = wr_ctrl ? ctrl_m : ctrl_q;
    if (set_lock) ctrl_d[pkrc_pkg::CTRL_LOCK_B] = 1'b1;
    if (clr_syson) ctrl_d[pkrc_pkg::CTRL_SYSON_B] = 1'b0;
    if (set_stby) ctrl_d[pkrc_pkg::CTRL_STBY_B] = 1'b1;
    if (clr_stby) ctrl_d[pkrc_pkg::CTRL_STBY_B] = 1'b0;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= pkrc_pkg::CTRL_RST;
      time_q <= pkrc_pkg::TIME_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_time) time_q <= merge(time_q, wdata_q, wstrb_q);
    end
  end

  // write channels latched independently, answered once both are held
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  // read mux; unmapped answers SLVERR with zero data
  wire [31:0] stat_w = {30'h0, !hr_asserted_q, deb_lvl[0]};
  wire [31:0] seq_w = {27'h0, standby_o, system_on_o, in_powerdown_i, deb_lvl[1], fast_shutdown_o};
  wire [7:0] ra = s_axi_araddr;
  wire rd_ok = ra == pkrc_pkg::CTRL_OFS || ra == pkrc_pkg::TIME_OFS ||
               ra == pkrc_pkg::STAT_OFS || ra == pkrc_pkg::EVT_OFS || ra == pkrc_pkg::SEQ_OFS;
  wire [31:0] rd_mux = (ra == pkrc_pkg::CTRL_OFS) ? ctrl_q :
                       (ra == pkrc_pkg::TIME_OFS) ? time_q :
                       (ra == pkrc_pkg::STAT_OFS) ? stat_w :
                       (ra == pkrc_pkg::EVT_OFS) ? {29'h0, evt_q} :
                       (ra == pkrc_pkg::SEQ_OFS) ? seq_w : 32'h0000_0000;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // checks
  chk_key_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    key_masked |-> !wakeup_o) else $error("masked key woke device");
  chk_evt_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    (evt_q != 3'h0 && !wr_evt) |=> evt_q != 3'h0) else $error("event lost");
  chk_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    (irq_out_o == irq_pol) == (evt_q != 3'h0)) else $error("irq level wrong");
  chk_rreq_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    rr_fall |=> !host_reset_n_o && evt_q[1]) else $error("reset request not held");
  chk_zero_delay: assert property (@(posedge mclk_i) disable iff (rst_i)
    (hr_asserted_q && !hr_timing_q && trig && rel_ms == 10'h000 && !rr_fall && !sleep_start)
    |=> host_reset_n_o) else $error("zero delay release late");
  chk_long_lock: assert property (@(posedge mclk_i) disable iff (rst_i)
    (long_hit && !kf_edge) |=> ctrl_q[pkrc_pkg::CTRL_LOCK_B]) else $error("lock not set");
  chk_off_long: assert property (@(posedge mclk_i) disable iff (rst_i)
    (long_hit && kf == pkrc_pkg::PKRC_KF_OFF) |=> !system_on_o) else $error("system on kept");
  chk_lock_short: assert property (@(posedge mclk_i) disable iff (rst_i)
    (lock && short_rel) |-> !wakeup_o) else $error("short press woke locked");
  chk_press_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    key_fall |=> press_ms_q == 18'h00000) else $error("timer not restarted");
endmodule : pkrc_top
